//--- logic/eesa_serial_access.sv
// top: serial frame receiver, command check, reply builder and nvm sequencing
`timescale 1ns/1ps

// Operation
// - after a good fetch frame, frame select rising starts the byte fetch.
// - fetched byte goes into the very next reply frame if that frame starts after the full fetch time.
// - after a good program frame, frame select rising starts storing the data.
// - programming completes only if select stays high the full program time.
// - first reply after a program echoes the data used; host compares.
// - first readback command returns the stored byte two frames after writing.
// - second readback command returns the stored byte three frames after writing.
// - command codes: fetch 00, program 01, readback first 10, second 11.
// - done flag clears when an action starts and sets when it finishes.
// - bad parity or clock count not sixteen flags a fault, command skipped.
module eesa_serial_access
	import eesa_pkg::*;
#(
	parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic frame_select_n,
	input  wire logic sclk,
	input  wire logic mosi,
	output logic      miso,
	output logic      link_fault_flag,
	output logic      nvm_done_flag
);
	import eesa_pkg::*;

	function automatic logic odd_ok(input logic [FRAME_BITS-1:0] w);
		return ^w;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	// edges are found only after the second flop, so a metastable sample never reaches the shifter
	logic [1:0] selSync_reg;
	logic [1:0] sclkSync_reg;
	logic [1:0] mosiSync_reg;
	logic       selLast_reg;
	logic       sclkLast_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			selSync_reg  <= 2'h3;
			sclkSync_reg <= 2'h0;
			mosiSync_reg <= 2'h0;
			selLast_reg  <= 1'b1;
			sclkLast_reg <= 1'b0;
		end else begin
			selSync_reg  <= {selSync_reg[0], frame_select_n};
			sclkSync_reg <= {sclkSync_reg[0], sclk};
			mosiSync_reg <= {mosiSync_reg[0], mosi};
			selLast_reg  <= selSync_reg[1];
			sclkLast_reg <= sclkSync_reg[1];
		end
	end

	logic selActive;
	logic selFall;
	logic selRise;
	logic sclkRise;
	logic sclkFall;

	assign selActive = !selSync_reg[1];
	assign selFall   = selLast_reg && !selSync_reg[1];
	assign selRise   = !selLast_reg && selSync_reg[1];
	assign sclkRise  = selActive && !sclkLast_reg && sclkSync_reg[1];
	assign sclkFall  = selActive && sclkLast_reg && !sclkSync_reg[1];

	// ****************************************
	// request shifter and clock counter
	// ****************************************
	logic [FRAME_BITS-1:0] rxShift_reg;
	logic [CNT_W-1:0]      bitCount_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxShift_reg  <= '0;
			bitCount_reg <= '0;
		end else if (selFall) begin
			bitCount_reg <= '0;
		end else if (sclkRise) begin
			// a long frame keeps only its last sixteen bits, but its count still fails
			rxShift_reg <= {rxShift_reg[FRAME_BITS-2:0], mosiSync_reg[1]};
			// saturate so a long frame cannot wrap back to a legal count
			if (bitCount_reg != COUNT_MAX) begin
				bitCount_reg <= bitCount_reg + 1'b1;
			end
		end
	end

	logic                frameGood;
	eesa_cmd_t           rxCmd;
	logic [DATA_W-1:0]   rxData;
	logic [ADDR_W-1:0]   rxAddr;

	assign frameGood = (bitCount_reg == FRAME_COUNT) && odd_ok(rxShift_reg);
	assign rxCmd     = eesa_cmd_t'(rxShift_reg[POS_CMD_LO +: CMD_W]);
	assign rxData    = rxShift_reg[POS_DATA_LO +: DATA_W];
	assign rxAddr    = rxShift_reg[POS_ADDR_LO +: ADDR_W];

	// ****************************************
	// command acceptance at frame end
	// ****************************************
	logic              nvmStart;
	logic              nvmProgram;
	logic              nvmDone;
	logic [DATA_W-1:0] nvmData;
	eesa_cmd_t         lastCmd_reg;
	logic [ADDR_W-1:0] lastAddr_reg;
	logic [DATA_W-1:0] echoData_reg;
	logic              echoWrite_reg;

	assign nvmStart   = selRise && frameGood;
	// readback commands are fetches of the cell at the frame's address
	assign nvmProgram = (rxCmd == NVM_PROGRAM_CMD);

	// ****************************************
	// fault flag: judged at every frame end
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link_fault_flag <= 1'b0;
		end else if (selRise) begin
			link_fault_flag <= !frameGood;
		end
	end

	// ****************************************
	// echo fields: a bad frame keeps the last good command, address and data
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lastCmd_reg   <= NVM_FETCH_CMD;
			lastAddr_reg  <= '0;
			echoData_reg  <= '0;
			echoWrite_reg <= 1'b0;
		end else if (nvmStart) begin
			lastCmd_reg   <= rxCmd;
			lastAddr_reg  <= rxAddr;
			echoData_reg  <= rxData;
			echoWrite_reg <= nvmProgram;
		end
	end

	// ****************************************
	// completion flag
	// ****************************************
	// start and completion cannot meet: a select fall always aborts the action first
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nvm_done_flag <= 1'b1;
		end else if (nvmStart) begin
			nvm_done_flag <= 1'b0;
		end else if (nvmDone) begin
			nvm_done_flag <= 1'b1;
		end
	end

	// ****************************************
	// nvm sequencer
	// ****************************************
	// the select fall doubles as abort: a new frame before the timer ends leaves the cell untouched
	eesa_nvm #(
		.PROG_CYCLES (PROG_CYCLES)
	) u_nvm (
		.clock     (clock),
		.rst_n     (rst_n),
		.start     (nvmStart),
		.writeMode (nvmProgram),
		.abort     (selFall),
		.addr      (rxAddr),
		.wdata     (rxData),
		.rdata     (nvmData),
		.done      (nvmDone)
	);

	// ****************************************
	// reply builder and shifter
	// ****************************************
	logic [FRAME_BITS-1:0] reply;
	logic [FRAME_BITS-1:0] replyBody;
	logic [FRAME_BITS-1:0] txShift_reg;

	always_comb begin
		replyBody = '0;
		replyBody[POS_FAULT]                = link_fault_flag;
		replyBody[POS_DONE]                 = nvm_done_flag;
		replyBody[POS_CMD_LO +: CMD_W]      = lastCmd_reg;
		// program echoes the data it used; fetch and readbacks give the stored byte
		replyBody[POS_DATA_LO +: DATA_W]    = echoWrite_reg ? echoData_reg : nvmData;
		replyBody[POS_ADDR_LO +: ADDR_W]    = lastAddr_reg;
		reply                               = replyBody;
		reply[POS_PARITY]                   = !(^replyBody);
	end

	// reply is frozen at the select fall, so flag changes during a frame show only in the next one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txShift_reg <= '0;
			miso        <= 1'b0;
		end else if (selFall) begin
			txShift_reg <= reply;
			miso        <= reply[FRAME_BITS-1];
		end else if (sclkFall) begin
			txShift_reg <= {txShift_reg[FRAME_BITS-2:0], 1'b0};
			miso        <= txShift_reg[FRAME_BITS-2];
		end
	end

endmodule

//--- logic/eesa_pkg.sv
// package: frame layout, commands, states and timing for the eeprom serial access block
package eesa_pkg;

	// ****************************************
	// frame layout
	// ****************************************
	localparam int FRAME_BITS   = 16;
	localparam int CNT_W        = 5;
	localparam int POS_PARITY   = 15;
	localparam int POS_FAULT    = 14;
	localparam int POS_DONE     = 13;
	localparam int POS_CMD_LO   = 11;
	localparam int CMD_W        = 2;
	localparam int POS_DATA_LO  = 4;
	localparam int DATA_W       = 7;
	localparam int POS_ADDR_LO  = 0;
	localparam int ADDR_W       = 3;
	localparam int NVM_DEPTH    = 8;
	localparam logic [4:0]        FRAME_COUNT = 5'h10;
	localparam logic [4:0]        COUNT_MAX   = 5'h1f;
	localparam logic [DATA_W-1:0] ERASED_DATA = 7'h7f;

	// ****************************************
	// commands and states
	// ****************************************
	typedef enum logic [1:0] {
		NVM_FETCH_CMD       = 2'b00,
		NVM_PROGRAM_CMD     = 2'b01,
		READBACK_FIRST_CMD  = 2'b10,
		READBACK_SECOND_CMD = 2'b11
	} eesa_cmd_t;

	typedef enum logic [1:0] {
		NVM_IDLE    = 2'b00,
		NVM_FETCH   = 2'b01,
		NVM_PROGRAM = 2'b10
	} eesa_nvm_state_t;

	// ****************************************
	// timing
	// ****************************************
	localparam int TIMER_W        = 20;
	localparam int CLK_PERIOD_NS  = 50;
	localparam int T_FETCH_NS     = 20000;
	localparam int T_PROGRAM_US   = 5000;
	localparam int FETCH_CYCLES   = (T_FETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROGRAM_CYCLES = (T_PROGRAM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- logic/eesa_nvm.sv
// nonvolatile byte array with timed fetch and program actions
`timescale 1ns/1ps
module eesa_nvm
	import eesa_pkg::*;
#(
	parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    start,
	input  wire logic                    writeMode,
	input  wire logic                    abort,
	input  wire logic [ADDR_W-1:0]       addr,
	input  wire logic [DATA_W-1:0]       wdata,
	output logic      [DATA_W-1:0]       rdata,
	output logic                         done
);
	import eesa_pkg::*;

	logic [DATA_W-1:0]  mem [NVM_DEPTH];
	eesa_nvm_state_t    state_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic [ADDR_W-1:0]  addr_reg;
	logic [DATA_W-1:0]  wdata_reg;
	logic               expire;

	assign expire = (timer_reg == '0);

	// ****************************************
	// action sequencer
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= NVM_IDLE;
			timer_reg <= '0;
			addr_reg  <= '0;
			wdata_reg <= '0;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				addr_reg  <= addr;
				wdata_reg <= wdata;
				state_reg <= writeMode ? NVM_PROGRAM : NVM_FETCH;
				timer_reg <= writeMode ? TIMER_W'(PROG_CYCLES - 1) : TIMER_W'(FETCH_CYCLES - 1);
			end else begin
				case (state_reg)
					NVM_IDLE: begin
						state_reg <= NVM_IDLE;
					end
					NVM_FETCH, NVM_PROGRAM: begin
						// a new frame cuts the action short; no completion then
						if (abort) begin
							state_reg <= NVM_IDLE;
						end else if (expire) begin
							state_reg <= NVM_IDLE;
							done      <= 1'b1;
						end else begin
							timer_reg <= timer_reg - 1'b1;
						end
					end
					default: begin
						state_reg <= NVM_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// storage: the cell changes only at the end of a full program time
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NVM_DEPTH; i++) begin
				mem[i] <= ERASED_DATA;
			end
			rdata <= '0;
		end else if (!start && !abort && expire) begin
			if (state_reg == NVM_PROGRAM) begin
				mem[addr_reg] <= wdata_reg;
				rdata         <= wdata_reg;
			end else if (state_reg == NVM_FETCH) begin
				rdata <= mem[addr_reg];
			end
		end
	end

endmodule

//--- tb/eesa_host_model.sv
// host model: serial master issuing frames
`timescale 1ns/1ps
module eesa_host_model (
	input  wire logic clock,
	output logic      frame_select_n,
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		frame_select_n = 1'b1;
		sclk           = 1'b0;
		mosi           = 1'b0;
	end
	// ****
	// frame
	// ****
	// sclk half period 4 clocks = 400 ns period, still outside frames
	task automatic xfer(input logic [15:0] req, input int n, output logic [15:0] rep);
		rep = 16'h0;
		frame_select_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			mosi <= req[15-i];
			repeat (4) @(posedge clock);
			sclk <= 1'b1;
			rep = {rep[14:0], miso};
			repeat (4) @(posedge clock);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge clock);
		frame_select_n <= 1'b1;
		// released line never shows its last bit
		mosi <= ~mosi;
	endtask
endmodule

//--- tb/eesa_serial_access_properties.sv
// checker: timing relations at the serial access ports
`timescale 1ns/1ps
module eesa_sa_props
	import eesa_pkg::*;
#(
	parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic frame_select_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic link_fault_flag,
	input wire logic nvm_done_flag
);
	// ****
	// helpers
	// ****
	localparam int MIN_ACT = (PROG_CYCLES < FETCH_CYCLES) ? PROG_CYCLES : FETCH_CYCLES;
	logic [19:0] hiCnt;
	logic [3:0]  loCnt;
	logic [3:0]  edgeAge;
	logic [4:0]  bitCnt;
	logic [15:0] rxWord;
	logic        sclkPrev;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hiCnt    <= 20'h0;
			loCnt    <= 4'h0;
			edgeAge  <= 4'h0;
			bitCnt   <= 5'h0;
			rxWord   <= 16'h0;
			sclkPrev <= 1'b0;
		end else begin
			sclkPrev <= sclk;
			hiCnt    <= frame_select_n ? hiCnt + 20'(hiCnt != 20'hfffff) : 20'h0;
			loCnt    <= !frame_select_n ? loCnt + 4'(loCnt != 4'hf) : 4'h0;
			edgeAge  <= ((sclkPrev && !sclk) || (!frame_select_n && hiCnt != 20'h0)) ? 4'h0
				: edgeAge + 4'(edgeAge != 4'hf);
			if (!frame_select_n && hiCnt != 20'h0) begin
				bitCnt <= 5'h0;
			end else if (!frame_select_n && !sclkPrev && sclk) begin
				bitCnt <= bitCnt + 5'h1;
				rxWord <= {rxWord[14:0], miso};
			end
		end
	end
	// ****
	// assertions
	// ****
	AST_FLAGS_HOLD: assert property (loCnt > 4'h6 |-> $stable(link_fault_flag) && $stable(nvm_done_flag))
		else $error("flag moved inside a frame");
	AST_DONE_RISE_TIME: assert property ($rose(nvm_done_flag) |-> hiCnt >= 20'(MIN_ACT))
		else $error("done rose too early");
	AST_DONE_FALL_AT_END: assert property ($fell(nvm_done_flag) |-> hiCnt inside {[1:8]})
		else $error("done fell away from frame end");
	AST_FAULT_AT_END: assert property ($changed(link_fault_flag) |-> hiCnt inside {[1:8]})
		else $error("fault moved away from frame end");
	AST_FAULT_SKIPS: assert property ($rose(link_fault_flag) |-> $stable(nvm_done_flag))
		else $error("action started on faulty frame");
	AST_MISO_IDLE: assert property (hiCnt > 20'h8 |-> $stable(miso))
		else $error("reply line moved while idle");
	AST_MISO_EDGE: assert property ($changed(miso) |-> edgeAge <= 4'h8)
		else $error("reply bit moved without a shift edge");
	AST_REPLY_PARITY: assert property ($rose(frame_select_n) && bitCnt == 5'h10 |-> ^rxWord)
		else $error("reply parity even");
	AST_REPLY_FAULT: assert property ($rose(frame_select_n) && bitCnt == 5'h10 |-> rxWord[14] == link_fault_flag)
		else $error("reply fault bit differs from flag");
	cover property ($rose(nvm_done_flag));
	cover property ($rose(link_fault_flag));
	cover property ($fell(nvm_done_flag));
endmodule

bind eesa_serial_access eesa_sa_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clock(clock), .rst_n(rst_n),
	.frame_select_n(frame_select_n), .sclk(sclk), .mosi(mosi), .miso(miso),
	.link_fault_flag(link_fault_flag), .nvm_done_flag(nvm_done_flag));

//--- tb/tb_top.sv
// bench: frame scenarios for the serial access block
`timescale 1ns/1ps
module tb_top;
	import eesa_pkg::*;
	logic        clock;
	logic        rst_n;
	logic        frameSelectN;
	logic        sclk;
	logic        mosi;
	logic        miso;
	logic        linkFault;
	logic        nvmDone;
	logic [15:0] r;
	int          n_errors  = 0;
	int          cmp_count = 0;

	eesa_serial_access #(.PROG_CYCLES(50)) DUT (.clock(clock), .rst_n(rst_n), .frame_select_n(frameSelectN),
		.sclk(sclk), .mosi(mosi), .miso(miso), .link_fault_flag(linkFault), .nvm_done_flag(nvmDone));
	eesa_host_model host (.clock(clock), .frame_select_n(frameSelectN), .sclk(sclk), .mosi(mosi), .miso(miso));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// ****
	// helpers
	// ****
	function automatic logic [15:0] rq(logic [1:0] c, logic [6:0] d, logic [2:0] a, logic bad);
		logic [14:0] w;
		w = {2'b00, c, d, 1'b0, a};
		return {~^w ^ bad, w};
	endfunction
	function automatic logic [15:0] rw(logic f, logic dn, logic [1:0] c, logic [6:0] d, logic [2:0] a);
		logic [14:0] w;
		w = {f, dn, c, d, 1'b0, a};
		return {~^w, w};
	endfunction
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic frame(logic [15:0] req, int n);
		host.xfer(req, n, r);
		repeat (8) @(posedge clock);
	endtask
	task automatic wait_done();
		int i;
		for (i = 0; i < 600 && nvmDone !== 1'b1; i++) @(posedge clock);
		if (i == 600) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	// ****
	// scenarios
	// ****
	task automatic s_program_verify();
		frame(rq(2'b01, 7'h2a, 3'h5, 1'b0), 16);
		chk("reset reply", r, rw(1'b0, 1'b1, 2'b00, 7'h00, 3'h0));
		wait_done();
		frame(rq(2'b10, 7'h00, 3'h5, 1'b0), 16);
		chk("write echo", r, rw(1'b0, 1'b1, 2'b01, 7'h2a, 3'h5));
		wait_done();
		frame(rq(2'b11, 7'h00, 3'h5, 1'b0), 16);
		chk("readback one", r, rw(1'b0, 1'b1, 2'b10, 7'h2a, 3'h5));
		wait_done();
		frame(rq(2'b00, 7'h00, 3'h3, 1'b0), 16);
		chk("readback two", r, rw(1'b0, 1'b1, 2'b11, 7'h2a, 3'h5));
		wait_done();
	endtask
	task automatic s_bad_frames();
		frame(rq(2'b00, 7'h00, 3'h6, 1'b1), 16);
		chk("fetch reply", r, rw(1'b0, 1'b1, 2'b00, 7'h7f, 3'h3));
		chk("fault pin", {15'h0, linkFault}, 16'h1);
		frame(rq(2'b00, 7'h00, 3'h6, 1'b0), 12);
		chk("parity fault", r, rw(1'b1, 1'b1, 2'b00, 7'h7f, 3'h3) >> 4);
		chk("done kept", {15'h0, nvmDone}, 16'h1);
		frame(rq(2'b00, 7'h00, 3'h6, 1'b0), 16);
		chk("count fault", r, rw(1'b1, 1'b1, 2'b00, 7'h7f, 3'h3));
		wait_done();
	endtask
	task automatic s_abort();
		frame(rq(2'b01, 7'h55, 3'h1, 1'b0), 16);
		chk("fetch six", r, rw(1'b0, 1'b1, 2'b00, 7'h7f, 3'h6));
		chk("done low", {15'h0, nvmDone}, 16'h0);
		frame(rq(2'b00, 7'h00, 3'h1, 1'b0), 16);
		chk("aborted echo", r, rw(1'b0, 1'b0, 2'b01, 7'h55, 3'h1));
		wait_done();
		frame(rq(2'b00, 7'h00, 3'h0, 1'b0), 16);
		chk("cell kept", r, rw(1'b0, 1'b1, 2'b00, 7'h7f, 3'h1));
		wait_done();
	endtask

	initial begin
		rst_n = 1'b0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		s_program_verify();
		s_bad_frames();
		s_abort();
		tally_and_finish();
	end
endmodule
